//--- design/csx_cond_check.sv
// Purpose: Evaluates the 4-bit condition field against the ALU flags
// Assumes: flags ordered N Z C V, msb first
// Notes: The sticky saturation flag is not an input here
`timescale 1ns/1ps
module csx_cond_check (
    csx_cond_if.check cif
);
    import csx_pkg::*;
    logic n;
    logic z;
    logic c;
    logic v;
    always_comb begin
        n = cif.flags[3];
        z = cif.flags[2];
        c = cif.flags[1];
        v = cif.flags[0];
        // Only N Z C V reach this table
        case (cif.cond)
            4'h0: cif.pass = z;
            4'h1: cif.pass = ~z;
            4'h2: cif.pass = c;
            4'h3: cif.pass = ~c;
            4'h4: cif.pass = n;
            4'h5: cif.pass = ~n;
            4'h6: cif.pass = v;
            4'h7: cif.pass = ~v;
            4'h8: cif.pass = c & ~z;
            4'h9: cif.pass = ~c | z;
            4'ha: cif.pass = (n == v);
            4'hb: cif.pass = (n != v);
            4'hc: cif.pass = ~z & (n == v);
            4'hd: cif.pass = z | (n != v);
            4'he: cif.pass = 1'b1;
            default: cif.pass = 1'b0;
        endcase
    end
endmodule : csx_cond_check

//--- design/csx_cond_if.sv
// Purpose: Carrier between the unit and its condition checker
// Assumes: Single clock domain
// Notes: Combinational request and answer
`timescale 1ns/1ps
interface csx_cond_if;
    logic [3:0] cond;
    logic [3:0] flags;
    logic pass;
    modport unit (output cond, output flags, input pass);
    modport check (input cond, input flags, output pass);
endinterface : csx_cond_if

//--- design/csx_pkg.sv
// Purpose: Shared constants and types for the core status and exception unit
// Assumes: 32-bit data path, standard status word layout
// Notes: All field positions, encodings and vectors live here
package csx_pkg;
    // ****************************************
    // Status word layout
    // ****************************************
    localparam int unsigned CSX_BIT_N = 31;
    localparam int unsigned CSX_BIT_Z = 30;
    localparam int unsigned CSX_BIT_C = 29;
    localparam int unsigned CSX_BIT_V = 28;
    localparam int unsigned CSX_BIT_Q = 27;
    localparam int unsigned CSX_BIT_J = 24;
    localparam int unsigned CSX_BIT_I = 7;
    localparam int unsigned CSX_BIT_F = 6;
    localparam int unsigned CSX_BIT_T = 5;
    localparam int unsigned CSX_MODE_HI = 4;
    localparam int unsigned CSX_NUM_SAVED = 5;

    // ****************************************
    // Mode encodings
    // ****************************************
    localparam logic [4:0] CSX_MODE_USR = 5'h10;
    localparam logic [4:0] CSX_MODE_FIQ = 5'h11;
    localparam logic [4:0] CSX_MODE_IRQ = 5'h12;
    localparam logic [4:0] CSX_MODE_SVC = 5'h13;
    localparam logic [4:0] CSX_MODE_ABT = 5'h17;
    localparam logic [4:0] CSX_MODE_UND = 5'h1b;
    localparam logic [4:0] CSX_MODE_SYS = 5'h1f;

    // Saved-word bank indices
    localparam logic [2:0] CSX_BANK_SVC = 3'h0;
    localparam logic [2:0] CSX_BANK_ABT = 3'h1;
    localparam logic [2:0] CSX_BANK_UND = 3'h2;
    localparam logic [2:0] CSX_BANK_IRQ = 3'h3;
    localparam logic [2:0] CSX_BANK_FIQ = 3'h4;
    localparam logic [2:0] CSX_BANK_NONE = 3'h7;

    // ****************************************
    // Vectors and reset values
    // ****************************************
    localparam logic [31:0] CSX_VEC_RST = 32'h0000_0000;
    localparam logic [31:0] CSX_VEC_UND = 32'h0000_0004;
    localparam logic [31:0] CSX_VEC_SWT = 32'h0000_0008;
    localparam logic [31:0] CSX_VEC_PAB = 32'h0000_000c;
    localparam logic [31:0] CSX_VEC_DAB = 32'h0000_0010;
    localparam logic [31:0] CSX_VEC_IRQ = 32'h0000_0018;
    localparam logic [31:0] CSX_VEC_FIQ = 32'h0000_001c;
    localparam logic [31:0] CSX_STATUS_RESET = 32'h0000_00d3;
    localparam logic [31:0] CSX_ZERO = 32'h0000_0000;

    // Return offsets added to the current pc
    localparam logic [31:0] CSX_OFS_2 = 32'h0000_0002;
    localparam logic [31:0] CSX_OFS_4 = 32'h0000_0004;
    localparam logic [31:0] CSX_OFS_8 = 32'h0000_0008;

    // Condition field
    localparam int unsigned CSX_COND_HI = 31;
    localparam int unsigned CSX_COND_LO = 28;

    typedef enum logic [6:0] {
        CSX_EXC_NONE = 7'b000_0000,
        CSX_EXC_RST  = 7'b000_0001,
        CSX_EXC_DAB  = 7'b000_0010,
        CSX_EXC_FIQ  = 7'b000_0100,
        CSX_EXC_IRQ  = 7'b000_1000,
        CSX_EXC_PAB  = 7'b001_0000,
        CSX_EXC_UND  = 7'b010_0000,
        CSX_EXC_SWT  = 7'b100_0000
    } csx_exc_t;
endpackage : csx_pkg

//--- design/csx_unit.sv
// Purpose: Status word and exception entry/return logic of the core
// Assumes: Pipeline supplies execute-stage info on the same clock
// Notes: Banked r8-r14 are stored here and read by index
`timescale 1ns/1ps
module csx_unit (
    input wire logic clock,
    input wire logic nrst,
    input wire logic fast_irq_req,
    input wire logic irq_req,
    input wire logic data_abort,
    input wire logic ex_valid,
    input wire logic [31:0] ex_instr,
    input wire logic [31:0] ex_pc,
    input wire logic ex_prefetch_abort,
    input wire logic ex_breakpoint_instruction,
    input wire logic ex_undefined,
    input wire logic ex_software_trap,
    input wire logic alu_flags_we,
    input wire logic [3:0] alu_flags,
    input wire logic saturation_set,
    input wire logic write_status_instruction,
    input wire logic write_status_saved,
    input wire logic [3:0] write_status_mask,
    input wire logic [31:0] write_status_data,
    input wire logic exc_return,
    input wire logic [31:0] return_offset,
    input wire logic bank_we,
    input wire logic [3:0] bank_widx,
    input wire logic [31:0] bank_wdata,
    input wire logic [3:0] bank_ridx,
    output logic [31:0] bank_rdata,
    output logic [31:0] current_status_word,
    output logic [31:0] saved_status_word,
    output logic ex_execute,
    output logic redirect,
    output logic [31:0] redirect_pc,
    output logic [6:0] exc_taken
);
    import csx_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic fiq_s;
    logic irq_s;
    logic dab_s;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {fast_irq_req, irq_req, data_abort};
            sync_b <= sync_a;
        end
    end
    assign fiq_s = sync_b[2];
    assign irq_s = sync_b[1];
    assign dab_s = sync_b[0];

    // ****************************************
    // Condition check
    // ****************************************
    csx_cond_if cif ();
    csx_cond_check u_cond (
        .cif(cif)
    );
    logic [31:0] cur;
    logic [31:0] saved [CSX_NUM_SAVED];
    logic pending_fiq;
    assign cif.cond = ex_instr[CSX_COND_HI:CSX_COND_LO];
    assign cif.flags = cur[CSX_BIT_N:CSX_BIT_V];
    // Compact and bytecode streams carry no condition field
    logic cond_ok;
    assign cond_ok = cur[CSX_BIT_T] | cur[CSX_BIT_J] | cif.pass;

    // ****************************************
    // Priority selection
    // ****************************************
    csx_exc_t next_exc;
    logic fiq_live;
    logic irq_live;
    assign fiq_live = (fiq_s | pending_fiq) & ~cur[CSX_BIT_F];
    assign irq_live = irq_s & ~cur[CSX_BIT_I];
    always_comb begin
        next_exc = CSX_EXC_NONE;
        // Aborted or breakpoint fetches only fire at execute
        if (dab_s) begin
            next_exc = CSX_EXC_DAB;
        end else if (fiq_live) begin
            next_exc = CSX_EXC_FIQ;
        end else if (irq_live) begin
            next_exc = CSX_EXC_IRQ;
        end else if (ex_valid && (ex_prefetch_abort || ex_breakpoint_instruction)) begin
            next_exc = CSX_EXC_PAB;
        end else if (ex_valid && cond_ok && ex_undefined) begin
            next_exc = CSX_EXC_UND;
        end else if (ex_valid && cond_ok && ex_software_trap) begin
            next_exc = CSX_EXC_SWT;
        end
    end

    // ****************************************
    // Entry decode
    // ****************************************
    logic [4:0] new_mode;
    logic [2:0] new_bank;
    logic [31:0] new_vec;
    logic [31:0] new_ofs;
    always_comb begin
        new_mode = cur[CSX_MODE_HI:0];
        new_bank = CSX_BANK_NONE;
        new_vec = CSX_VEC_RST;
        new_ofs = CSX_OFS_4;
        case (next_exc)
            CSX_EXC_DAB: begin
                new_mode = CSX_MODE_ABT;
                new_bank = CSX_BANK_ABT;
                new_vec = CSX_VEC_DAB;
                new_ofs = CSX_OFS_8;
            end
            CSX_EXC_FIQ: begin
                new_mode = CSX_MODE_FIQ;
                new_bank = CSX_BANK_FIQ;
                new_vec = CSX_VEC_FIQ;
            end
            CSX_EXC_IRQ: begin
                new_mode = CSX_MODE_IRQ;
                new_bank = CSX_BANK_IRQ;
                new_vec = CSX_VEC_IRQ;
            end
            CSX_EXC_PAB: begin
                new_mode = CSX_MODE_ABT;
                new_bank = CSX_BANK_ABT;
                new_vec = CSX_VEC_PAB;
            end
            CSX_EXC_UND: begin
                new_mode = CSX_MODE_UND;
                new_bank = CSX_BANK_UND;
                new_vec = CSX_VEC_UND;
                new_ofs = cur[CSX_BIT_T] ? CSX_OFS_2 : CSX_OFS_4;
            end
            CSX_EXC_SWT: begin
                new_mode = CSX_MODE_SVC;
                new_bank = CSX_BANK_SVC;
                new_vec = CSX_VEC_SWT;
                new_ofs = cur[CSX_BIT_T] ? CSX_OFS_2 : CSX_OFS_4;
            end
            default: new_bank = CSX_BANK_NONE;
        endcase
    end
    logic take;
    logic [31:0] link_value;
    assign take = (next_exc != CSX_EXC_NONE);
    assign link_value = ex_pc + new_ofs;

    // ****************************************
    // Current status word
    // ****************************************
    function automatic logic [31:0] merge(input logic [31:0] base);
        logic [31:0] r;
        r = base;
        for (int b = 0; b < 4; b++) begin
            if (write_status_mask[b]) r[b*8 +: 8] = write_status_data[b*8 +: 8];
        end
        return r;
    endfunction : merge
    logic [31:0] wr_word;
    always_comb wr_word = merge(cur);
    logic [2:0] cur_bank;
    always_comb begin
        case (cur[CSX_MODE_HI:0])
            CSX_MODE_SVC: cur_bank = CSX_BANK_SVC;
            CSX_MODE_ABT: cur_bank = CSX_BANK_ABT;
            CSX_MODE_UND: cur_bank = CSX_BANK_UND;
            CSX_MODE_IRQ: cur_bank = CSX_BANK_IRQ;
            CSX_MODE_FIQ: cur_bank = CSX_BANK_FIQ;
            default: cur_bank = CSX_BANK_NONE;
        endcase
    end
    logic status_wr;
    assign status_wr = write_status_instruction && !write_status_saved;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur <= CSX_STATUS_RESET;
        end else if (take) begin
            cur[CSX_MODE_HI:0] <= new_mode;
            cur[CSX_BIT_I] <= 1'b1;
            cur[CSX_BIT_F] <= cur[CSX_BIT_F] | (next_exc == CSX_EXC_FIQ);
            cur[CSX_BIT_T] <= 1'b0;
            cur[CSX_BIT_J] <= 1'b0;
        end else if (exc_return && cur_bank != CSX_BANK_NONE) begin
            cur <= saved[cur_bank];
        end else if (status_wr) begin
            cur <= wr_word;
            // Event in the write cycle must not be lost
            if (saturation_set) cur[CSX_BIT_Q] <= 1'b1;
        end else begin
            if (alu_flags_we) cur[CSX_BIT_N:CSX_BIT_V] <= alu_flags;
            if (saturation_set) cur[CSX_BIT_Q] <= 1'b1;
        end
    end

    // ****************************************
    // Saved status words and fast chaining
    // ****************************************
    logic [31:0] saved_cur;
    logic [31:0] saved_wr;
    assign saved_cur = (cur_bank != CSX_BANK_NONE) ? saved[cur_bank] : CSX_ZERO;
    always_comb saved_wr = merge(saved_cur);
    genvar gi;
    generate
        for (gi = 0; gi < CSX_NUM_SAVED; gi++) begin : g_saved
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    saved[gi] <= CSX_ZERO;
                end else if (take && new_bank == 3'(gi)) begin
                    saved[gi] <= cur;
                end else if (write_status_instruction && write_status_saved
                             && cur_bank == 3'(gi)) begin
                    saved[gi] <= saved_wr;
                end
            end
        end
    endgenerate

    // Fast request seen with an abort is replayed next cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pending_fiq <= 1'b0;
        end else begin
            pending_fiq <= (next_exc == CSX_EXC_DAB) && fiq_s && !cur[CSX_BIT_F];
        end
    end

    // ****************************************
    // Banked registers r8..r14
    // ****************************************
    // Index 0..6 is r8..r14; fast mode banks all, others r13/r14
    logic [31:0] usr_reg [7];
    logic [31:0] fiq_reg [7];
    logic [31:0] sp_bank [4];
    logic [31:0] lr_bank [4];
    logic in_fiq;
    assign in_fiq = (cur[CSX_MODE_HI:0] == CSX_MODE_FIQ);
    generate
        for (gi = 0; gi < 7; gi++) begin : g_r8
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    usr_reg[gi] <= CSX_ZERO;
                    fiq_reg[gi] <= CSX_ZERO;
                end else if (take && new_bank == CSX_BANK_FIQ && gi == 6) begin
                    fiq_reg[gi] <= link_value;
                end else if (bank_we && bank_widx == 4'(gi + 8)) begin
                    if (in_fiq) fiq_reg[gi] <= bank_wdata;
                    else if (gi < 5 || cur_bank == CSX_BANK_NONE) usr_reg[gi] <= bank_wdata;
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_sp
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    sp_bank[gi] <= CSX_ZERO;
                    lr_bank[gi] <= CSX_ZERO;
                end else if (take && new_bank == 3'(gi)) begin
                    lr_bank[gi] <= link_value;
                end else if (bank_we && cur_bank == 3'(gi)) begin
                    if (bank_widx == 4'hd) sp_bank[gi] <= bank_wdata;
                    if (bank_widx == 4'he) lr_bank[gi] <= bank_wdata;
                end
            end
        end
    endgenerate
    logic [31:0] next_rdata;
    logic [2:0] ri;
    always_comb begin
        ri = 3'(bank_ridx - 4'h8);
        next_rdata = CSX_ZERO;
        if (bank_ridx >= 4'h8 && bank_ridx <= 4'he) begin
            if (in_fiq) next_rdata = fiq_reg[ri];
            else if (cur_bank != CSX_BANK_NONE && bank_ridx == 4'hd)
                next_rdata = sp_bank[cur_bank[1:0]];
            else if (cur_bank != CSX_BANK_NONE && bank_ridx == 4'he)
                next_rdata = lr_bank[cur_bank[1:0]];
            else next_rdata = usr_reg[ri];
        end
    end

    logic [31:0] ret_link;
    assign ret_link = in_fiq ? fiq_reg[6]
        : (cur_bank != CSX_BANK_NONE) ? lr_bank[cur_bank[1:0]] : CSX_ZERO;

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bank_rdata <= CSX_ZERO;
            current_status_word <= CSX_STATUS_RESET;
            saved_status_word <= CSX_ZERO;
            ex_execute <= 1'b0;
            redirect <= 1'b1;
            redirect_pc <= CSX_VEC_RST;
            exc_taken <= CSX_EXC_RST;
        end else begin
            bank_rdata <= next_rdata;
            current_status_word <= cur;
            saved_status_word <= saved_cur;
            ex_execute <= ex_valid && cond_ok && !take;
            redirect <= take || exc_return;
            redirect_pc <= take ? new_vec : ret_link - return_offset;
            exc_taken <= next_exc;
        end
    end
endmodule : csx_unit

//--- verification/csx_far_side.sv
// Purpose: Far-side model of the interrupt controller and memory system
// Assumes: Bench asks for each raise with a one-cycle command
// Notes: Interrupt lines stay up until taken; aborts are one-cycle answers
`timescale 1ns/1ps
module csx_far_side (
    input logic clock,
    input logic nrst,
    input logic [2:0] raise,
    input logic [6:0] exc_taken,
    output logic fast_irq_req,
    output logic irq_req,
    output logic data_abort
);
    // ****************************************
    // Request lines
    // ****************************************
    // Levels held so a masked request waits, as a real controller would
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fast_irq_req <= 1'b0;
            irq_req <= 1'b0;
            data_abort <= 1'b0;
        end else begin
            fast_irq_req <= raise[2] | (fast_irq_req & ~exc_taken[2]);
            irq_req <= raise[1] | (irq_req & ~exc_taken[3]);
            data_abort <= raise[0];
        end
    end
endmodule : csx_far_side

//--- verification/csx_unit_properties.sv
// Purpose: Port-level properties of the status and exception unit
// Assumes: Registered outputs, status output one cycle behind
// Notes: Bound to every csx_unit instance
`timescale 1ns/1ps
module csx_unit_properties (
    input logic clock,
    input logic nrst,
    input logic write_status_instruction,
    input logic exc_return,
    input logic alu_flags_we,
    input logic [3:0] alu_flags,
    input logic ex_valid,
    input logic ex_prefetch_abort,
    input logic ex_breakpoint_instruction,
    input logic ex_undefined,
    input logic ex_software_trap,
    input logic [31:0] current_status_word,
    input logic ex_execute,
    input logic redirect,
    input logic [31:0] redirect_pc,
    input logic [6:0] exc_taken
);
    import csx_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [31:0] vec;
    logic [2:0] hist;
    logic any_tag;
    assign any_tag = ex_prefetch_abort | ex_breakpoint_instruction | ex_undefined
        | ex_software_trap;
    always_comb begin
        case (exc_taken)
            CSX_EXC_DAB: vec = CSX_VEC_DAB;
            CSX_EXC_FIQ: vec = CSX_VEC_FIQ;
            CSX_EXC_IRQ: vec = CSX_VEC_IRQ;
            CSX_EXC_PAB: vec = CSX_VEC_PAB;
            CSX_EXC_UND: vec = CSX_VEC_UND;
            CSX_EXC_SWT: vec = CSX_VEC_SWT;
            default: vec = CSX_VEC_RST;
        endcase
    end
    // Only status writes or returns may drop the sticky flag
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hist <= 3'h0;
        end else begin
            hist <= {hist[1:0], write_status_instruction | exc_return};
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    property p_one_kind; $onehot0(exc_taken); endproperty
    a_one_kind: assert property (p_one_kind) else $error("two kinds taken");
    property p_take_jumps; |exc_taken |-> redirect; endproperty
    a_take_jumps: assert property (p_take_jumps) else $error("take without jump");
    property p_vector; |exc_taken |-> redirect_pc == vec; endproperty
    a_vector: assert property (p_vector) else $error("bad vector");
    property p_irq_entry; exc_taken == CSX_EXC_IRQ |-> ##[0:1]
        (current_status_word[CSX_BIT_I] && current_status_word[4:0] == CSX_MODE_IRQ);
    endproperty
    a_irq_entry: assert property (p_irq_entry) else $error("bad irq entry");
    property p_fiq_entry; exc_taken == CSX_EXC_FIQ |-> ##[0:1]
        (current_status_word[7:6] == 2'h3 && current_status_word[4:0] == CSX_MODE_FIQ);
    endproperty
    a_fiq_entry: assert property (p_fiq_entry) else $error("bad fiq entry");
    property p_bytecode; |exc_taken[3:1] |-> ##[0:1] !current_status_word[CSX_BIT_J];
    endproperty
    a_bytecode: assert property (p_bytecode) else $error("bytecode kept");
    property p_exec; ex_execute |-> $past(ex_valid && !any_tag); endproperty
    a_exec: assert property (p_exec) else $error("tagged instr executed");
    property p_sticky; $fell(current_status_word[CSX_BIT_Q]) |-> |hist; endproperty
    a_sticky: assert property (p_sticky) else $error("sticky flag lost");
    property p_flags; alu_flags_we && !write_status_instruction && !exc_return ##1 !redirect
        |-> ##1 current_status_word[31:28] == $past(alu_flags, 2);
    endproperty
    a_flags: assert property (p_flags) else $error("flags not updated");
    c_irq: cover property (exc_taken == CSX_EXC_IRQ);
    c_chain: cover property (exc_taken == CSX_EXC_DAB ##1 exc_taken == CSX_EXC_FIQ);
    c_exec: cover property (ex_execute);
endmodule : csx_unit_properties
bind csx_unit csx_unit_properties u_props (
    .clock, .nrst, .write_status_instruction, .exc_return, .alu_flags_we,
    .alu_flags, .ex_valid, .ex_prefetch_abort, .ex_breakpoint_instruction,
    .ex_undefined, .ex_software_trap, .current_status_word, .ex_execute,
    .redirect, .redirect_pc, .exc_taken
);

//--- verification/csx_unit_test.sv
// Purpose: Self-checking bench for the status and exception unit
// Assumes: Inputs change on the falling edge
// Notes: Far-side model raises interrupts and aborts
`timescale 1ns/1ps
module csx_unit_test;
    import csx_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic ex_valid = 1'b0, alu_flags_we = 1'b0, saturation_set = 1'b0, exc_return = 1'b0;
    logic write_status_instruction = 1'b0, bank_we = 1'b0;
    logic [3:0] tags = 4'h0, alu_flags = 4'h0, write_status_mask = 4'h0;
    logic [3:0] bank_widx = 4'h0, bank_ridx = 4'h0;
    logic [31:0] ex_instr = 32'h0000_0000, ex_pc = 32'h0000_0000;
    logic [31:0] write_status_data = 32'h0000_0000, bank_wdata = 32'h0000_0000;
    logic [2:0] raise = 3'h0;
    logic fast_irq_req, irq_req, data_abort, ex_execute, redirect;
    logic [31:0] bank_rdata, current_status_word, saved_status_word, redirect_pc;
    logic [6:0] exc_taken;
    logic [31:0] m_csw, pc;
    logic [3:0] f;
    int n_errors = 0, n_tests = 0, seed = 4;
    csx_exc_t kinds [4] = '{CSX_EXC_PAB, CSX_EXC_PAB, CSX_EXC_UND, CSX_EXC_SWT};
    logic [31:0] vecs [4] = '{CSX_VEC_PAB, CSX_VEC_PAB, CSX_VEC_UND, CSX_VEC_SWT};
    logic [4:0] modes [4] = '{CSX_MODE_ABT, CSX_MODE_ABT, CSX_MODE_UND, CSX_MODE_SVC};
    always #5 clock = ~clock;
    csx_far_side u_far (.clock, .nrst, .raise, .exc_taken, .fast_irq_req, .irq_req,
        .data_abort);
    csx_unit DUT (.clock, .nrst, .fast_irq_req, .irq_req, .data_abort, .ex_valid,
        .ex_instr, .ex_pc, .ex_prefetch_abort(tags[3]), .ex_breakpoint_instruction(tags[2]),
        .ex_undefined(tags[1]), .ex_software_trap(tags[0]), .alu_flags_we, .alu_flags,
        .saturation_set, .write_status_instruction, .write_status_saved(1'b0),
        .write_status_mask, .write_status_data, .exc_return,
        .return_offset(32'h0000_0004), .bank_we, .bank_widx, .bank_wdata, .bank_ridx,
        .bank_rdata, .current_status_word, .saved_status_word, .ex_execute, .redirect,
        .redirect_pc, .exc_taken);
    // ****************************************
    // Tasks and model
    // ****************************************
    task automatic close_out;
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic check(input string what, logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic wstat(input logic [3:0] m, logic [31:0] d, int settle);
        write_status_mask = m;
        write_status_data = d;
        write_status_instruction = 1'b1;
        tick(1);
        write_status_instruction = 1'b0;
        tick(settle);
    endtask : wstat
    task automatic bwr(input logic [3:0] idx, logic [31:0] d);
        bank_widx = idx;
        bank_wdata = d;
        bank_we = 1'b1;
        tick(1);
        bank_we = 1'b0;
    endtask : bwr
    task automatic rd(input logic [3:0] idx, logic [31:0] exp, string what);
        bank_ridx = idx;
        tick(2);
        check(what, bank_rdata, exp);
    endtask : rd
    task automatic restart;
        nrst = 1'b0;
        tick(8);
        check("reset status", current_status_word, CSX_STATUS_RESET);
        check("reset take", {25'h0, exc_taken}, {25'h0, CSX_EXC_RST});
        nrst = 1'b1;
        tick(2);
        wstat(4'hf, 32'h0000_0010, 3);
        m_csw = 32'h0000_0010;
        check("user status", current_status_word, m_csw);
    endtask : restart
    // Bounded wait for the one-cycle jump
    task automatic take(input csx_exc_t kind, logic [31:0] vec);
        int i = 0;
        while (redirect !== 1'b1 && i < 20) begin
            tick(1);
            i++;
        end
        if (i == 20) begin
            n_errors++;
            close_out();
        end
        check("taken", {25'h0, exc_taken}, {25'h0, kind});
        check("target", redirect_pc, vec);
    endtask : take
    function automatic logic cond_ok(input logic [3:0] c, g);
        logic r;
        case (c[3:1])
            3'h0: r = g[2];
            3'h1: r = g[1];
            3'h2: r = g[3];
            3'h3: r = g[0];
            3'h4: r = g[1] & ~g[2];
            3'h5: r = g[3] == g[0];
            3'h6: r = ~g[2] & (g[3] == g[0]);
            default: r = 1'b1;
        endcase
        return r ^ c[0];
    endfunction : cond_ok
    initial begin
        restart();
        saturation_set = 1'b1;
        tick(1);
        saturation_set = 1'b0;
        for (int r = 0; r < 4; r++) begin
            f = 4'($random(seed));
            alu_flags = f;
            alu_flags_we = 1'b1;
            tick(1);
            alu_flags_we = 1'b0;
            tick(3);
            check("flags", current_status_word, {f, 1'b1, 27'h000_0010});
            ex_valid = 1'b1;
            for (int c = 0; c < 15; c++) begin
                ex_instr = {4'(c), 28'h000_0000};
                tick(1);
                check("execute", {31'h0, ex_execute}, {31'h0, cond_ok(4'(c), f)});
            end
            ex_valid = 1'b0;
        end
        wstat(4'h8, 32'h0000_0000, 3);
        check("sticky clear", current_status_word, 32'h0000_0010);
        wstat(4'h1, 32'h0000_0090, 3);
        raise = 3'h2;
        tick(1);
        raise = 3'h0;
        repeat (8) begin
            tick(1);
            check("masked", {25'h0, exc_taken}, 32'h0000_0000);
        end
        wstat(4'h1, 32'h0000_0010, 0);
        take(CSX_EXC_IRQ, CSX_VEC_IRQ);
        restart();
        pc = $random(seed) & 32'hffff_fffc;
        ex_pc = pc;
        bwr(4'hd, 32'h0000_1111);
        wstat(4'h8, 32'h0100_0000, 3);
        m_csw = 32'h0100_0010;
        raise = 3'h2;
        tick(1);
        raise = 3'h0;
        take(CSX_EXC_IRQ, CSX_VEC_IRQ);
        tick(3);
        check("irq status", current_status_word, 32'h0000_0092);
        check("irq saved", saved_status_word, m_csw);
        rd(4'he, pc + 32'h0000_0004, "irq link");
        bwr(4'hd, 32'h0000_2222);
        rd(4'hd, 32'h0000_2222, "irq stack");
        exc_return = 1'b1;
        tick(1);
        exc_return = 1'b0;
        take(CSX_EXC_NONE, pc);
        tick(3);
        check("restored", current_status_word, m_csw);
        rd(4'hd, 32'h0000_1111, "user stack");
        restart();
        raise = 3'h5;
        tick(1);
        raise = 3'h0;
        take(CSX_EXC_DAB, CSX_VEC_DAB);
        tick(1);
        take(CSX_EXC_FIQ, CSX_VEC_FIQ);
        tick(3);
        check("fast status", current_status_word, 32'h0000_00d1);
        check("fast saved", saved_status_word, 32'h0000_0097);
        for (int k = 0; k < 4; k++) begin
            restart();
            pc = $random(seed) & 32'hffff_fffc;
            ex_pc = pc;
            ex_instr = 32'he000_0000;
            tags = 4'h8 >> k;
            tick(4);
            check("flushed", {25'h0, exc_taken}, 32'h0000_0000);
            ex_valid = 1'b1;
            tick(1);
            ex_valid = 1'b0;
            tags = 4'h0;
            take(kinds[k], vecs[k]);
            tick(3);
            check("mode", {27'h0, current_status_word[4:0]}, {27'h0, modes[k]});
            rd(4'he, pc + 32'h0000_0004, "link");
        end
        close_out();
    end
endmodule : csx_unit_test
